// ---- design/dssl_pkg.sv ----
// constants and types shared by the single-wire debug link files
package dssl_pkg;

  // bit timing, counted in target clock ticks
  localparam logic [4:0] TICKS_PER_BIT    = 5'h10;
  localparam logic [4:0] RX_SAMPLE_TICKS  = 5'h0A;
  localparam logic [4:0] TX1_SPEEDUP_TICK = 5'h07;
  localparam logic [4:0] TX0_LOW_TICKS    = 5'h0D;
  localparam logic [4:0] ACK_LOW_TICKS    = 5'h10;
  localparam logic [5:0] ACK_MIN_GAP      = 6'h20;
  localparam logic [9:0] TIMEOUT_TICKS    = 10'h200;

  // frame layout
  localparam logic [2:0] BYTE_LAST_BIT    = 3'h7;
  localparam logic [4:0] TX_WORD_BITS     = 5'h10;

  // divided target clock when the fast source is not selected
  localparam logic [1:0] TGT_DIV_LAST     = 2'h1;

  // receive buffer shape
  localparam int         RX_FIFO_WIDTH    = 9;
  localparam int         RX_FIFO_DEPTH    = 8;

  // reset values
  localparam logic       PIN_IDLE_LEVEL   = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_TX,
    ST_ACK_LOW,
    ST_ACK_SPEED
  } dssl_state_t;

endpackage : dssl_pkg

// ---- design/dssl_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dssl_sync (
  // clock
  input  wire logic sys_clk_in,
  // raw pin
  input  wire logic pin_in,
  // filtered level
  output logic      level_out
);

  logic s1;
  logic s2;
  logic s3;

  // no reset: the level must follow the pin while reset is held
  always_ff @(posedge sys_clk_in) begin
    s1 <= pin_in;
    s2 <= s1;
    s3 <= s2;
  end

  always_ff @(posedge sys_clk_in) begin
    if (s2 == s3) begin
      level_out <= s3;
    end
  end

endmodule : dssl_sync

// ---- design/dssl_fifo.sv ----
// small valid/ready fifo for received bytes
`timescale 1ns/1ps
module dssl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem[rptr];

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wptr] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : dssl_fifo

// ---- design/dssl_link.sv ----
// single-wire debug link: bit engine, handshake pulse, mode capture
//
// Contract
// - each bit lasts 16 target ticks; values go most significant bit first
// - 512 target ticks without host falling edge abandon transfer, return idle
// - all bit timing counts ticks of the selected target clock
// - line is pulled high; only brief speedup pulses drive it high
// - received bit sampled ten ticks after the recognised falling edge
// - device sending one drives speedup at tick seven; host released before
// - device sending zero holds low thirteen ticks, then speedup pulse
// - handshake pulse: sixteen ticks low, then speedup pulse
// - handshake starts at least 32 ticks after last bit's sixteenth tick
// - handshake has no timeout; waits for command execution indefinitely
// - wait or stop before execution discards command; no handshake, none pending
// - pin is mode select during reset, serial link afterwards
// - device opens handshake with its own falling edge; host keeps off
// - handshake disabled after reset; enable and disable commands switch it
// - frames start with 8-bit opcode, then 16-bit address and/or data
`timescale 1ns/1ps
module dssl_link (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // target clock choice
  input  wire logic        serial_clock_select_in,
  // debug pin
  input  wire logic        serial_debug_pin_in,
  output logic             serial_debug_pin_out,
  output logic             serial_debug_pin_oe_n_out,
  // mode strap
  output logic             mode_select_out,
  // received bytes toward the command decoder
  output logic [7:0]       rx_byte_out,
  output logic             rx_first_out,
  output logic             rx_valid_out,
  input  wire logic        rx_ready_in,
  output logic             rx_overflow_out,
  // reply word from the command side
  input  wire logic [15:0] tx_word_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  // command execution side
  input  wire logic        cmd_end_in,
  input  wire logic        cmd_done_in,
  input  wire logic        ack_on_in,
  input  wire logic        ack_off_in,
  input  wire logic        cpu_wait_stop_in,
  output logic             ack_enabled_out,
  output logic             cmd_pending_out
);

  dssl_pkg::dssl_state_t state;

  logic        lvl;
  logic        lvl_prev;
  logic        fall;
  logic [1:0]  div;
  logic        tick;
  logic [4:0]  tcnt;
  logic        bit_end;
  logic        samp;
  logic [7:0]  rx_sh;
  logic [2:0]  rx_cnt;
  logic [7:0]  hold;
  logic        hold_first;
  logic        hold_valid;
  logic        fifo_in_ready;
  logic        expect_op;
  logic [15:0] tx_sh;
  logic [4:0]  tx_bits;
  logic [9:0]  tmo_cnt;
  logic        busy;
  logic        timeout;
  logic [5:0]  gap_cnt;
  logic        ack_en;
  logic        cmd_pending;
  logic        ack_due;
  logic        ack_go;
  logic        abort;
  logic        next_oe_n;
  logic        next_pin;

  dssl_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .pin_in     (serial_debug_pin_in),
    .level_out  (lvl)
  );

  // pin level is a strap while reset is held
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mode_select_out <= lvl;
    end
  end

  // follows the pin through reset, so a strap held low makes no edge on release
  always_ff @(posedge sys_clk_in) begin
    lvl_prev <= lvl;
  end

  assign fall = lvl_prev && !lvl;

  // target clock: every cycle, or divided
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || div == dssl_pkg::TGT_DIV_LAST) begin
      div <= '0;
    end else begin
      div <= div + 2'h1;
    end
  end

  assign tick = serial_clock_select_in || (div == dssl_pkg::TGT_DIV_LAST);

  assign bit_end = (state == dssl_pkg::ST_RX || state == dssl_pkg::ST_TX) && tick &&
                   (tcnt + 5'h01 == dssl_pkg::TICKS_PER_BIT);
  assign samp    = (state == dssl_pkg::ST_RX) && tick &&
                   (tcnt + 5'h01 == dssl_pkg::RX_SAMPLE_TICKS);
  assign busy    = (state == dssl_pkg::ST_RX) || (state == dssl_pkg::ST_TX) ||
                   (rx_cnt != '0) || (tx_bits != '0);
  assign timeout = busy && tick && !fall &&
                   (tmo_cnt + 10'h001 == dssl_pkg::TIMEOUT_TICKS);
  assign ack_go  = (state == dssl_pkg::ST_IDLE) && !fall && ack_due &&
                   (gap_cnt == dssl_pkg::ACK_MIN_GAP);
  assign abort   = (state == dssl_pkg::ST_IDLE) && fall && ack_due;

  // bit engine
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= dssl_pkg::ST_IDLE;
      tcnt  <= '0;
    end else begin
      case (state)
        dssl_pkg::ST_IDLE: begin
          tcnt <= '0;
          if (fall && !ack_due) begin
            state <= (tx_bits != '0) ? dssl_pkg::ST_TX : dssl_pkg::ST_RX;
          end else if (ack_go) begin
            state <= dssl_pkg::ST_ACK_LOW;
          end
        end
        dssl_pkg::ST_RX, dssl_pkg::ST_TX: begin
          if (timeout || bit_end) begin
            state <= dssl_pkg::ST_IDLE;
            tcnt  <= '0;
          end else if (tick) begin
            tcnt <= tcnt + 5'h01;
          end
        end
        dssl_pkg::ST_ACK_LOW: begin
          if (tick) begin
            if (tcnt + 5'h01 == dssl_pkg::ACK_LOW_TICKS) begin
              state <= dssl_pkg::ST_ACK_SPEED;
              tcnt  <= '0;
            end else begin
              tcnt <= tcnt + 5'h01;
            end
          end
        end
        dssl_pkg::ST_ACK_SPEED: begin
          if (tick) begin
            state <= dssl_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= dssl_pkg::ST_IDLE;
          tcnt  <= '0;
        end
      endcase
    end
  end

  // inter-edge watchdog, restarted by every host falling edge
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !busy || fall || timeout) begin
      tmo_cnt <= '0;
    end else if (tick) begin
      tmo_cnt <= tmo_cnt + 10'h001;
    end
  end

  // ticks since the sixteenth tick of the last bit
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      gap_cnt <= dssl_pkg::ACK_MIN_GAP;
    end else if (bit_end) begin
      gap_cnt <= '0;
    end else if (tick && gap_cnt != dssl_pkg::ACK_MIN_GAP) begin
      gap_cnt <= gap_cnt + 6'h01;
    end
  end

  // receive shifter, first bit lands in the top
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rx_sh <= '0;
    end else if (samp) begin
      rx_sh <= {rx_sh[6:0], lvl};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || timeout) begin
      rx_cnt <= '0;
    end else if (bit_end && state == dssl_pkg::ST_RX) begin
      rx_cnt <= rx_cnt + 3'h1;
    end
  end

  // opcode marker: first byte after reset, a timeout or a finished command
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || timeout || cmd_end_in) begin
      expect_op <= 1'b1;
    end else if (bit_end && state == dssl_pkg::ST_RX && rx_cnt == dssl_pkg::BYTE_LAST_BIT) begin
      expect_op <= 1'b0;
    end
  end

  // holding stage; the host cannot be stalled, so a full buffer loses a byte
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hold            <= '0;
      hold_first      <= 1'b0;
      hold_valid      <= 1'b0;
      rx_overflow_out <= 1'b0;
    end else begin
      rx_overflow_out <= 1'b0;
      if (bit_end && state == dssl_pkg::ST_RX && rx_cnt == dssl_pkg::BYTE_LAST_BIT) begin
        if (hold_valid && !fifo_in_ready) begin
          rx_overflow_out <= 1'b1;
        end else begin
          hold       <= rx_sh;
          hold_first <= expect_op;
          hold_valid <= 1'b1;
        end
      end else if (hold_valid && fifo_in_ready) begin
        hold_valid <= 1'b0;
      end
    end
  end

  dssl_fifo #(
    .WIDTH (dssl_pkg::RX_FIFO_WIDTH),
    .DEPTH (dssl_pkg::RX_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (hold_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({hold_first, hold}),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  ({rx_first_out, rx_byte_out})
  );

  // transmit shifter, most significant bit leaves first
  assign tx_ready_out = (tx_bits == '0) && (state != dssl_pkg::ST_TX);

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || timeout) begin
      tx_sh   <= '0;
      tx_bits <= '0;
    end else if (tx_valid_in && tx_ready_out) begin
      tx_sh   <= tx_word_in;
      tx_bits <= dssl_pkg::TX_WORD_BITS;
    end else if (bit_end && state == dssl_pkg::ST_TX) begin
      tx_sh   <= {tx_sh[14:0], 1'b0};
      tx_bits <= tx_bits - 5'h01;
    end
  end

  // handshake enable, off after reset
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || ack_off_in) begin
      ack_en <= 1'b0;
    end else if (ack_on_in) begin
      ack_en <= 1'b1;
    end
  end

  // wait or stop discards the command outright
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || cpu_wait_stop_in) begin
      cmd_pending <= 1'b0;
    end else if (cmd_end_in) begin
      cmd_pending <= 1'b1;
    end else if (cmd_done_in || abort) begin
      cmd_pending <= 1'b0;
    end
  end

  // no timeout on the wait; only handshake start, discard or host abort end it
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || cpu_wait_stop_in) begin
      ack_due <= 1'b0;
    end else if (cmd_done_in && cmd_pending && ack_en) begin
      ack_due <= 1'b1;
    end else if (ack_go || abort) begin
      ack_due <= 1'b0;
    end
  end

  // pin drive; high only during speedup pulses
  always_comb begin
    next_oe_n = 1'b1;
    next_pin  = 1'b1;
    case (state)
      dssl_pkg::ST_TX: begin
        if (tx_sh[15]) begin
          if (tcnt == dssl_pkg::TX1_SPEEDUP_TICK) begin
            next_oe_n = 1'b0;
          end
        end else if (tcnt < dssl_pkg::TX0_LOW_TICKS) begin
          next_oe_n = 1'b0;
          next_pin  = 1'b0;
        end else if (tcnt == dssl_pkg::TX0_LOW_TICKS) begin
          next_oe_n = 1'b0;
        end
      end
      dssl_pkg::ST_ACK_LOW: begin
        next_oe_n = 1'b0;
        next_pin  = 1'b0;
      end
      dssl_pkg::ST_ACK_SPEED: begin
        next_oe_n = 1'b0;
      end
      default: begin
        next_oe_n = 1'b1;
        next_pin  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      serial_debug_pin_oe_n_out <= 1'b1;
      serial_debug_pin_out      <= dssl_pkg::PIN_IDLE_LEVEL;
    end else begin
      serial_debug_pin_oe_n_out <= next_oe_n;
      serial_debug_pin_out      <= next_pin;
    end
  end

  assign ack_enabled_out = ack_en;
  assign cmd_pending_out = cmd_pending;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_rx_begin;
    (state == dssl_pkg::ST_IDLE) && fall && !ack_due && (tx_bits == '0) && serial_clock_select_in;
  endsequence

  sequence s_drive_low;
    !serial_debug_pin_oe_n_out && !serial_debug_pin_out;
  endsequence

  sequence s_ack_wave;
    s_drive_low [*8] ##1 s_drive_low [*8] ##1
    (!serial_debug_pin_oe_n_out && serial_debug_pin_out);
  endsequence

  property p_bit_len;
    s_rx_begin |=> (state == dssl_pkg::ST_RX) [*8] ##1 (state == dssl_pkg::ST_RX) [*8]
                   ##1 (state == dssl_pkg::ST_IDLE);
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("receive bit not 16 ticks");

  property p_rx_sample;
    samp |=> (rx_sh[0] == $past(lvl)) && ($past(tcnt) == 5'h09);
  endproperty
  a_rx_sample: assert property (p_rx_sample) else $error("bad receive sample");

  property p_timeout;
    timeout |=> (state == dssl_pkg::ST_IDLE) && (rx_cnt == '0) && (tx_bits == '0);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not idle");

  property p_tx1_speed;
    (state == dssl_pkg::ST_TX && tx_sh[15] && tcnt == 5'h07) |=>
      !serial_debug_pin_oe_n_out && serial_debug_pin_out;
  endproperty
  a_tx1_speed: assert property (p_tx1_speed) else $error("missing speedup on one");

  property p_tx0_low;
    (state == dssl_pkg::ST_TX && !tx_sh[15] && tcnt < 5'h0D) |=> s_drive_low;
  endproperty
  a_tx0_low: assert property (p_tx0_low) else $error("zero not held low");

  property p_ack_pulse;
    (ack_go && serial_clock_select_in) |=> ##1 s_ack_wave;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bad handshake pulse");

  property p_ack_gap;
    (bit_end && serial_clock_select_in) |=> (!ack_go) [*8] ##1 (!ack_go) [*8] ##1
      (!ack_go) [*8] ##1 (!ack_go) [*7];
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("handshake too early");

  property p_ack_needs_enable;
    ack_go |-> ack_en && !$past(cpu_wait_stop_in);
  endproperty
  a_ack_needs_enable: assert property (p_ack_needs_enable) else $error("handshake while off");

  property p_discard;
    cpu_wait_stop_in |=> !cmd_pending && !ack_due && !ack_go;
  endproperty
  a_discard: assert property (p_discard) else $error("command not discarded");

  property p_ack_waits;
    (ack_due && !ack_go && !abort && !cpu_wait_stop_in) |=> ack_due;
  endproperty
  a_ack_waits: assert property (p_ack_waits) else $error("handshake dropped");

  property p_idle_released;
    (state == dssl_pkg::ST_IDLE && $past(state) == dssl_pkg::ST_IDLE) |-> serial_debug_pin_oe_n_out;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("pin driven in idle");

endmodule : dssl_link

// ---- dv/dssl_host_model.sv ----
// host pod model: opens every bit on the single debug wire and reads replies
`timescale 1ns/1ps
module dssl_host_model (
  // clock
  input  wire logic sys_clk_in,
  // resolved wire level
  input  wire logic wire_in,
  // host drive and its active-low enable
  output logic      drv_out,
  output logic      drv_oe_n_out
);
  // cycles per target tick; the bench sets 2 for the divided clock
  int scale = 1;

  initial begin
    drv_out      = 1'h1;
    drv_oe_n_out = 1'h1;
  end

  // hold one drive state for cyc target ticks, cyc times scale cycles
  task automatic drv(input logic oe_n, input logic val, input int cyc);
    @(posedge sys_clk_in);
    drv_oe_n_out <= oe_n;
    drv_out      <= val;
    repeat (cyc * scale - 1) @(posedge sys_clk_in);
  endtask : drv

  // 21 cycles a bit so the next fall lands after the device's bit end
  task automatic send_bit(input logic b);
    if (b) begin
      drv(1'h0, 1'h0, 4);
      drv(1'h0, 1'h1, 1);
      drv(1'h1, 1'h1, 16);
    end else begin
      drv(1'h0, 1'h0, 13);
      drv(1'h0, 1'h1, 1);
      drv(1'h1, 1'h1, 7);
    end
  endtask : send_bit

  // released long before the device speedup, so no drive conflict
  task automatic read_bit(output logic b);
    drv(1'h0, 1'h0, 3);
    drv(1'h1, 1'h1, 7);
    @(negedge sys_clk_in);
    b = wire_in;
    drv(1'h1, 1'h1, 11);
  endtask : read_bit
endmodule : dssl_host_model

// ---- dv/testbench.sv ----
// self-checking bench for the single-wire debug link
`timescale 1ns/1ps
module testbench;
  localparam int C_END  = 0;
  localparam int C_DONE = 1;
  localparam int C_ON   = 2;
  localparam int C_OFF  = 3;
  localparam int C_WS   = 4;

  logic        sys_clk_in;
  logic        reset_in;
  logic [4:0]  ctl;
  logic        rx_ready;
  logic [15:0] tx_word;
  logic        tx_valid;
  logic        sel;
  logic        pin_wire;
  logic        dev_pin;
  logic        dev_oe_n;
  logic        host_pin;
  logic        host_oe_n;
  logic        mode_sel;
  logic [7:0]  rx_byte;
  logic        rx_first;
  logic        rx_valid;
  logic        rx_ovf;
  logic        tx_ready;
  logic        ack_en;
  logic        pending;
  int          fails;
  int          n_checks;
  int          n_ovf;
  int          run;
  int          last_run;

  // pulled-up wire; a released line reads high
  assign pin_wire = !dev_oe_n ? dev_pin : (!host_oe_n ? host_pin : 1'h1);

  dssl_link dssl_link_i (
    .sys_clk_in                (sys_clk_in),
    .reset_in                  (reset_in),
    .serial_clock_select_in    (sel),
    .serial_debug_pin_in       (pin_wire),
    .serial_debug_pin_out      (dev_pin),
    .serial_debug_pin_oe_n_out (dev_oe_n),
    .mode_select_out           (mode_sel),
    .rx_byte_out               (rx_byte),
    .rx_first_out              (rx_first),
    .rx_valid_out              (rx_valid),
    .rx_ready_in               (rx_ready),
    .rx_overflow_out           (rx_ovf),
    .tx_word_in                (tx_word),
    .tx_valid_in               (tx_valid),
    .tx_ready_out              (tx_ready),
    .cmd_end_in                (ctl[C_END]),
    .cmd_done_in               (ctl[C_DONE]),
    .ack_on_in                 (ctl[C_ON]),
    .ack_off_in                (ctl[C_OFF]),
    .cpu_wait_stop_in          (ctl[C_WS]),
    .ack_enabled_out           (ack_en),
    .cmd_pending_out           (pending)
  );

  dssl_host_model dssl_host_model_i (
    .sys_clk_in   (sys_clk_in),
    .wire_in      (pin_wire),
    .drv_out      (host_pin),
    .drv_oe_n_out (host_oe_n)
  );

  initial begin
    sys_clk_in = 1'h0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // overflow pulses and length of the latest device-driven low
  always @(posedge sys_clk_in) begin
    if (rx_ovf === 1'h1) n_ovf <= n_ovf + 1;
    if (dev_oe_n === 1'h0 && dev_pin === 1'h0) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run      <= 0;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic pulse(input int idx);
    @(posedge sys_clk_in);
    ctl[idx] <= 1'h1;
    @(posedge sys_clk_in);
    ctl[idx] <= 1'h0;
  endtask : pulse

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) dssl_host_model_i.send_bit(b[i]);
  endtask : send_byte

  task automatic drain(input logic first, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    while (rx_valid !== 1'h1) begin
      n++;
      if (n > 50) begin
        fails++;
        summarize();
      end
      @(negedge sys_clk_in);
    end
    chk("rx entry", {7'h0, first, b}, {7'h0, rx_first, rx_byte});
    @(posedge sys_clk_in);
    rx_ready <= 1'h1;
    @(posedge sys_clk_in);
    rx_ready <= 1'h0;
  endtask : drain

  task automatic quiet(input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(negedge sys_clk_in);
      if (dev_oe_n !== 1'h1) bad++;
    end
    chk("no drive", 16'h0, 16'(bad));
  endtask : quiet

  task automatic t_reset();
    dssl_host_model_i.drv(1'h0, 1'h0, 9);
    @(negedge sys_clk_in);
    chk("oe_n in reset", 16'h1, 16'(dev_oe_n));
    chk("ack en in reset", 16'h0, 16'(ack_en));
    chk("pending in reset", 16'h0, 16'(pending));
    chk("rx valid in reset", 16'h0, 16'(rx_valid));
    chk("tx ready in reset", 16'h1, 16'(tx_ready));
    @(posedge sys_clk_in);
    reset_in <= 1'h0;
    dssl_host_model_i.drv(1'h1, 1'h1, 4);
    chk("mode sel", 16'h0, 16'(mode_sel));
  endtask : t_reset

  // stalled consumer: 8 fifo entries plus the holding stage, then a drop
  task automatic t_fill();
    for (int i = 0; i < 10; i++) send_byte(8'hA0 + 8'(i));
    // last bit ends one cycle after the host model returns
    repeat (4) @(posedge sys_clk_in);
    chk("overflow pulses", 16'h1, 16'(n_ovf));
    for (int i = 0; i < 9; i++) drain(i == 0, 8'hA0 + 8'(i));
    @(negedge sys_clk_in);
    chk("rx empty", 16'h0, 16'(rx_valid));
  endtask : t_fill

  task automatic t_tmo();
    for (int i = 0; i < 3; i++) dssl_host_model_i.send_bit(1'h1);
    repeat (520) @(posedge sys_clk_in);
    send_byte(8'h81);
    drain(1'h1, 8'h81);
    chk("mode sel held", 16'h0, 16'(mode_sel));
  endtask : t_tmo

  // host stays off the wire for the whole handshake
  task automatic t_ack(input int dly, input logic first);
    time t0;
    int  n;
    pulse(C_ON);
    send_byte(8'hC6);
    t0 = $time;
    pulse(C_END);
    repeat (dly) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk("pending", 16'h1, 16'(pending));
    pulse(C_DONE);
    n = 0;
    @(negedge sys_clk_in);
    while (!(dev_oe_n === 1'h0 && dev_pin === 1'h0)) begin
      n++;
      if (n > 100) begin
        fails++;
        summarize();
      end
      @(negedge sys_clk_in);
    end
    if (dly == 0) chk("ack gap", 16'h1, 16'(($time - t0) / 40 >= 31));
    n = 0;
    while (dev_oe_n === 1'h0 && dev_pin === 1'h0 && n < 40) begin
      n++;
      @(negedge sys_clk_in);
    end
    chk("ack low", 16'h10, 16'(n));
    chk("ack speedup", 16'h1, 16'({dev_oe_n, dev_pin}));
    @(negedge sys_clk_in);
    chk("ack release", 16'h1, 16'(dev_oe_n));
    chk("pending cleared", 16'h0, 16'(pending));
    chk("ack en", 16'h1, 16'(ack_en));
    drain(first, 8'hC6);
  endtask : t_ack

  task automatic t_disc();
    send_byte(8'h5A);
    pulse(C_END);
    pulse(C_WS);
    pulse(C_DONE);
    @(negedge sys_clk_in);
    chk("pending after stop", 16'h0, 16'(pending));
    quiet(80);
    drain(1'h1, 8'h5A);
    pulse(C_OFF);
    send_byte(8'h3C);
    pulse(C_END);
    pulse(C_DONE);
    @(negedge sys_clk_in);
    chk("ack en off", 16'h0, 16'(ack_en));
    quiet(80);
    drain(1'h1, 8'h3C);
  endtask : t_disc

  // slow: divided target clock, each tick two cycles long
  task automatic t_tx(input logic slow);
    logic [15:0] got;
    logic        b;
    @(posedge sys_clk_in);
    if (slow) begin
      sel <= 1'h0;
      dssl_host_model_i.scale = 2;
    end
    tx_word  <= 16'h96C3;
    tx_valid <= 1'h1;
    @(posedge sys_clk_in);
    tx_valid <= 1'h0;
    @(negedge sys_clk_in);
    chk("tx ready loaded", 16'h0, 16'(tx_ready));
    for (int i = 15; i >= 0; i--) begin
      dssl_host_model_i.read_bit(b);
      got[i] = b;
    end
    chk("tx word", 16'h96C3, got);
    // thirteen ticks low; tick phase may trim one cycle off the first
    if (slow) chk("slow zero low", 16'h1, 16'(last_run inside {[25:26]}));
    else chk("tx zero low", 16'h0D, 16'(last_run));
    // with the fast clock the last bit ends one cycle after the host model returns
    repeat (3) @(negedge sys_clk_in);
    chk("tx ready free", 16'h1, 16'(tx_ready));
  endtask : t_tx

  initial begin
    reset_in = 1'h1;
    ctl      = 5'h00;
    rx_ready = 1'h0;
    tx_word  = 16'h0000;
    tx_valid = 1'h0;
    sel      = 1'h1;
    t_reset();
    t_fill();
    t_tmo();
    t_ack(0, 1'h0);
    t_ack(700, 1'h1);
    t_disc();
    t_tx(1'h0);
    t_tx(1'h1);
    summarize();
  end
endmodule : testbench
